// ==== design/mas_synth.sv ====
//
// Purpose: Four-channel speech/MIDI synthesizer with mixer, volume and PWM/DAC output
// Assumes: Core writes control through dedicated ports; sample bytes arrive on request
// Notes:   Output routing is strapped from pin b at reset release
`timescale 1ns/1ps
module mas_synth #(
    parameter int unsigned NUM_CH     = mas_pkg::NUM_CH,
    parameter int unsigned FIFO_DEPTH = mas_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                          core_clk_i,
    input  wire logic                          reset_n_i,
    // Dedicated control ports, no memory address
    input  wire logic [1:0]                    mixer_mode_i,
    input  wire logic [NUM_CH-1:0]             ch_start_i,
    input  wire logic [NUM_CH-1:0]             ch_stop_i,
    input  wire logic [NUM_CH-1:0]             ch_is_midi_i,
    input  wire logic [NUM_CH-1:0]             ch_adpcm_i,
    input  wire logic [NUM_CH*8-1:0]           ch_period_i,
    input  wire logic [NUM_CH*8-1:0]           envelope_value_i,
    input  wire logic [NUM_CH*2-1:0]           ch_wave_i,
    input  wire logic [NUM_CH*3-1:0]           ch_skip_i,
    input  wire logic [3:0]                    volume_i,
    input  wire logic                          out_sel_wr_i,
    input  wire logic                          out_sel_i,
    // Sample data feed
    input  wire logic [NUM_CH*8-1:0]           ch_data_i,
    input  wire logic [NUM_CH-1:0]             ch_data_end_i,
    output logic [NUM_CH*8-1:0]                channel_data_pointer_o,
    output logic [NUM_CH-1:0]                  ch_fetch_o,
    // Status
    output logic [NUM_CH-1:0]                  channel_flag_reg_o,
    output logic [NUM_CH-1:0]                  quick_io_code_o,
    output logic                               audio_output_select_reg_o,
    // Pins
    input  wire logic                          audio_out_pin_b_i,
    output logic                               audio_out_pin_a_o,
    output logic                               audio_out_pin_a_oe_o,
    output logic                               audio_out_pin_b_o,
    output logic                               audio_out_pin_b_oe_o,
    output logic [mas_pkg::DAC_W-1:0]          dac_code_o
);
    localparam int unsigned SW  = mas_pkg::SAMPLE_W;
    localparam int unsigned TDW = $clog2(mas_pkg::TICK_DIV);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [SW-1:0] sat_add(input logic [SW-1:0] a, input logic signed [SW:0] d);
        logic signed [SW+1:0] s;
        s = $signed({2'h0, a}) + d;
        if (s < 0) begin
            sat_add = '0;
        end else if (s > $signed({2'h0, {SW{1'b1}}})) begin
            sat_add = '1;
        end else begin
            sat_add = s[SW-1:0];
        end
    endfunction

    // ************************************************************
    // 1 MHz tick for the sample timers
    // ************************************************************
    logic [TDW-1:0] tick_cnt_q;
    logic           tick;
    assign tick = (tick_cnt_q == TDW'(mas_pkg::TICK_DIV - 1));

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    // ************************************************************
    // Channels
    // ************************************************************
    logic [NUM_CH-1:0]    flag_q;
    logic [NUM_CH-1:0]    qio_q;
    logic [NUM_CH-1:0]    fetch_q;
    logic [7:0]           timer_q  [NUM_CH];
    logic [7:0]           ptr_q    [NUM_CH];
    logic [SW-1:0]        sample_q [NUM_CH];
    logic [3:0]           step_q   [NUM_CH];
    logic [NUM_CH-1:0]    active;
    logic [NUM_CH-1:0]    advance;

    always_comb begin
        case (mixer_mode_i)
            mas_pkg::MIX_ONE: active = NUM_CH'(1);
            mas_pkg::MIX_TWO: active = NUM_CH'(3);
            default:          active = '1;
        endcase
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic [7:0]    period;
        logic [7:0]    env;
        logic [1:0]    wave;
        logic [2:0]    skip;
        logic [7:0]    din;
        logic [7:0]    wave_smp;
        logic [15:0]   prod;
        logic signed [SW:0] delta;

        assign period  = ch_period_i[c*8 +: 8];
        assign env     = envelope_value_i[c*8 +: 8];
        assign wave    = ch_wave_i[c*2 +: 2];
        assign skip    = ch_skip_i[c*3 +: 3];
        assign din     = ch_data_i[c*8 +: 8];
        // Overflow of the 8-bit up-counter requests a sample
        assign advance[c] = flag_q[c] && tick && (timer_q[c] == 8'hFF);

        always_comb begin
            case (wave)
                mas_pkg::WAVE_ADSR: wave_smp = ptr_q[c][7] ? ~ptr_q[c] : ptr_q[c];
                mas_pkg::WAVE_FULL: wave_smp = ptr_q[c][7] ? 8'hFF : 8'h00;
                default:            wave_smp = din;
            endcase
        end
        assign prod  = wave_smp * env;
        // ADPCM: 4-bit signed code scaled by adaptive step
        assign delta = $signed({{(SW-3){din[3]}}, din[3:0]}) <<< step_q[c][1:0];

        always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                flag_q[c]   <= 1'b0;
                qio_q[c]    <= 1'b0;
                fetch_q[c]  <= 1'b0;
                timer_q[c]  <= '0;
                ptr_q[c]    <= '0;
                sample_q[c] <= '0;
                step_q[c]   <= mas_pkg::ADPCM_STEP_INIT;
            end else begin
                fetch_q[c] <= advance[c];
                if (ch_start_i[c] && active[c]) begin
                    flag_q[c]   <= 1'b1;
                    timer_q[c]  <= period;
                    ptr_q[c]    <= '0;
                    step_q[c]   <= mas_pkg::ADPCM_STEP_INIT;
                end else if (ch_stop_i[c] || !active[c] || (advance[c] && ch_data_end_i[c])) begin
                    flag_q[c]   <= 1'b0;
                end else if (advance[c]) begin
                    timer_q[c]  <= period;
                    qio_q[c]    <= ~qio_q[c];
                    if (ch_is_midi_i[c]) begin
                        ptr_q[c]    <= ptr_q[c] + {5'h0, skip} + 8'h01;
                        sample_q[c] <= prod[15:8];
                    end else begin
                        ptr_q[c]    <= ptr_q[c] + 8'h01;
                        if (ch_adpcm_i[c]) begin
                            sample_q[c] <= sat_add(sample_q[c], delta);
                            if (din[2] && step_q[c] != mas_pkg::ADPCM_STEP_MAX) begin
                                step_q[c] <= step_q[c] + 4'h1;
                            end else if (!din[2] && step_q[c] != mas_pkg::ADPCM_STEP_INIT) begin
                                step_q[c] <= step_q[c] - 4'h1;
                            end
                        end else begin
                            sample_q[c] <= din;
                        end
                    end
                end else if (tick && flag_q[c]) begin
                    timer_q[c] <= timer_q[c] + 8'h01;
                end
            end
        end

        assign channel_data_pointer_o[c*8 +: 8] = ptr_q[c];
    end

    assign channel_flag_reg_o = flag_q;
    assign quick_io_code_o    = qio_q;
    assign ch_fetch_o         = fetch_q;

    // ************************************************************
    // Mixer and volume
    // ************************************************************
    localparam int unsigned MW = mas_pkg::MIX_W;
    logic [MW-1:0]     mix_sum;
    logic [MW+3:0]     scaled;
    mas_stream_if #(.WIDTH(MW)) mix_s ();

    always_comb begin
        mix_sum = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (flag_q[i]) begin
                mix_sum = mix_sum + MW'(sample_q[i]);
            end
        end
    end
    assign scaled = mix_sum * ({1'b0, volume_i} + 5'h01);

    logic           mix_valid_q;
    logic [MW-1:0]  mix_data_q;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mix_valid_q <= 1'b0;
            mix_data_q  <= '0;
        end else if (!mix_valid_q || mix_s.ready) begin
            mix_valid_q <= tick && (|flag_q);
            mix_data_q  <= scaled[MW+3:4];
        end
    end
    assign mix_s.valid = mix_valid_q;
    assign mix_s.data  = mix_data_q;

    logic          out_valid;
    logic          out_ready;
    logic [MW-1:0] out_data;
    mas_fifo #(.WIDTH(MW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .in_s        (mix_s),
        .out_valid_o (out_valid),
        .out_ready_i (out_ready),
        .out_data_o  (out_data)
    );

    // ************************************************************
    // Output select strap
    // ************************************************************
    logic strap_done_q;
    logic sel_q;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strap_done_q <= 1'b0;
            sel_q        <= mas_pkg::OUT_PWM;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            sel_q        <= audio_out_pin_b_i ? mas_pkg::OUT_DAC : mas_pkg::OUT_PWM;
        end else if (out_sel_wr_i) begin
            sel_q        <= out_sel_i;
        end
    end
    assign audio_output_select_reg_o = sel_q;

    // ************************************************************
    // PWM and DAC stages
    // ************************************************************
    localparam int unsigned PW = mas_pkg::PWM_W;
    logic [PW-1:0]  pwm_cnt_q;
    logic [PW-1:0]  pwm_duty_q;
    logic [MW-1:0]  dac_q;
    logic           pa_q;
    logic           pb_q;
    logic           pa_oe_q;
    logic           pb_oe_q;

    assign out_ready = strap_done_q && ((sel_q == mas_pkg::OUT_DAC) ? tick : (pwm_cnt_q == '1));

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwm_cnt_q  <= '0;
            pwm_duty_q <= '0;
            dac_q      <= '0;
        end else begin
            pwm_cnt_q <= pwm_cnt_q + 1'b1;
            if (out_valid && out_ready) begin
                pwm_duty_q <= out_data[MW-1:MW-PW];
                dac_q      <= out_data;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pa_q    <= 1'b0;
            pb_q    <= 1'b0;
            pa_oe_q <= 1'b0;
            pb_oe_q <= 1'b0;
        end else if (!strap_done_q || sel_q == mas_pkg::OUT_DAC) begin
            pa_q    <= 1'b0;
            pb_q    <= 1'b0;
            pa_oe_q <= strap_done_q;
            pb_oe_q <= 1'b0;
        end else begin
            pa_q    <= (pwm_cnt_q < pwm_duty_q);
            pb_q    <= !(pwm_cnt_q < pwm_duty_q);
            pa_oe_q <= 1'b1;
            pb_oe_q <= 1'b1;
        end
    end

    assign audio_out_pin_a_o    = pa_q;
    assign audio_out_pin_b_o    = pb_q;
    assign audio_out_pin_a_oe_o = pa_oe_q;
    assign audio_out_pin_b_oe_o = pb_oe_q;
    assign dac_code_o           = dac_q;
endmodule

// ==== shared/mas_pkg.sv ====
//
// Purpose: Constants and types shared by the audio synthesizer output block
// Assumes: 10 MHz core clock
// Notes:   All timing counts are derived from named times and the clock rate
//
package mas_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned TICK_HZ         = 1_000_000;
    localparam int unsigned TICK_DIV        = CLK_HZ / TICK_HZ;
    localparam int unsigned MAX_RATE_HZ     = 44_100;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int unsigned NUM_CH          = 4;
    localparam int unsigned SAMPLE_W        = 8;
    localparam int unsigned TIMER_W         = 8;
    localparam int unsigned ENV_W           = 8;
    localparam int unsigned VOL_W           = 4;
    localparam int unsigned PTR_W           = 8;
    localparam int unsigned MIX_W           = 10;
    localparam int unsigned PWM_W           = 9;
    localparam int unsigned DAC_W           = 10;
    localparam int unsigned FIFO_DEPTH      = 16;
    localparam int unsigned STEP_W          = 3;

    // ************************************************************
    // Codes
    // ************************************************************
    localparam logic [1:0] MIX_ONE          = 2'h0;
    localparam logic [1:0] MIX_TWO          = 2'h1;
    localparam logic [1:0] MIX_FOUR         = 2'h2;
    localparam logic [1:0] WAVE_TABLE       = 2'h0;
    localparam logic [1:0] WAVE_ADSR        = 2'h1;
    localparam logic [1:0] WAVE_FULL        = 2'h2;
    localparam logic       OUT_PWM          = 1'h0;
    localparam logic       OUT_DAC          = 1'h1;
    localparam logic [3:0] ADPCM_STEP_INIT  = 4'h0;
    localparam logic [3:0] ADPCM_STEP_MAX   = 4'hF;

    typedef enum logic [1:0] {
        MAS_IDLE,
        MAS_PLAY,
        MAS_DONE
    } mas_state_t;

endpackage

// ==== shared/mas_stream_if.sv ====
//
// Purpose: Valid/ready stream carrier between the mixer and the output FIFO
// Assumes: Single clock domain
// Notes:   Data is one volume-scaled mixed sample
//
`timescale 1ns/1ps
interface mas_stream_if #(
    parameter int unsigned WIDTH = 10
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);
endinterface

// ==== design/mas_fifo.sv ====
//
// Purpose: Sample FIFO between the mixer and the output stage
// Assumes: Synchronous reset-free storage, async reset on pointers
// Notes:   Depth must be a power of two
//
`timescale 1ns/1ps
module mas_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_n_i,
    // Fill side
    mas_stream_if.snk             in_s,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    assign empty       = (wr_q == rd_q);
    assign full        = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
    assign in_s.ready  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem_q[rd_q[AW-1:0]];
    assign push        = in_s.valid && !full;
    assign pop         = out_ready_i && !empty;

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_s.data;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

// ==== sim/mas_synth_assertions.sv ====
//
// Purpose: Port-level checks of the synthesizer top
// Assumes: One clock, async active-low reset
// Notes:   Channel 0 is active in every mixer mode, so channel checks watch it
//
`timescale 1ns/1ps
module mas_synth_assertions #(
    parameter int unsigned NUM_CH = 4
) (
    // Clock, reset and controls
    input wire logic              core_clk_i,
    input wire logic              reset_n_i,
    input wire logic [1:0]        mixer_mode_i,
    input wire logic [NUM_CH-1:0] ch_start_i,
    input wire logic [NUM_CH-1:0] ch_stop_i,
    input wire logic              out_sel_wr_i,
    input wire logic              out_sel_i,
    input wire logic              audio_out_pin_b_i,
    // Outputs watched
    input wire logic [NUM_CH-1:0] ch_fetch_o,
    input wire logic [NUM_CH-1:0] channel_flag_reg_o,
    input wire logic [NUM_CH-1:0] quick_io_code_o,
    input wire logic              audio_output_select_reg_o,
    input wire logic              audio_out_pin_a_oe_o,
    input wire logic              audio_out_pin_b_oe_o
);
    // ****************************************
    // Edges since reset and strap level copy
    // ****************************************
    logic [1:0] edge_q;
    logic       strap_q;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            edge_q  <= 2'h0;
            strap_q <= 1'h0;
        end else if (edge_q != 2'h2) begin
            edge_q  <= edge_q + 2'h1;
            strap_q <= (edge_q == 2'h0) ? audio_out_pin_b_i : strap_q;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence quiet_s;
        !ch_fetch_o[0] [*8];
    endsequence
    sequence sel_held_s(logic v);
        audio_output_select_reg_o == v && $past(audio_output_select_reg_o) == v;
    endsequence
    start_flag_a: assert property (
        edge_q != 2'h0 && ch_start_i[0] |=> channel_flag_reg_o[0])
        else $error("start did not raise the flag");
    stop_flag_a: assert property (
        ch_stop_i[0] && !ch_start_i[0] |=> !channel_flag_reg_o[0])
        else $error("stop did not clear the flag");
    one_channel_a: assert property (
        mixer_mode_i == mas_pkg::MIX_ONE |=> channel_flag_reg_o[NUM_CH-1:1] == '0)
        else $error("inactive channel still playing");
    fetch_gap_a: assert property (
        ch_fetch_o[0] |=> quiet_s)
        else $error("fetches closer than one tick");
    fetch_code_a: assert property (
        ch_fetch_o[0] && channel_flag_reg_o[0] && !$past(ch_start_i[0])
        |-> quick_io_code_o[0] != $past(quick_io_code_o[0], 3))
        else $error("quick code did not toggle on advance");
    strap_sel_a: assert property (
        edge_q == 2'h1 |-> audio_output_select_reg_o == strap_q)
        else $error("strap not copied to selection");
    dac_pins_a: assert property (
        ((edge_q == 2'h2) and sel_held_s(mas_pkg::OUT_DAC))
        |-> audio_out_pin_a_oe_o && !audio_out_pin_b_oe_o)
        else $error("DAC mode pin enables wrong");
    pwm_pins_a: assert property (
        ((edge_q == 2'h2) and sel_held_s(mas_pkg::OUT_PWM))
        |-> audio_out_pin_a_oe_o && audio_out_pin_b_oe_o)
        else $error("PWM mode pin enables wrong");
    sel_write_a: assert property (
        edge_q != 2'h0 && out_sel_wr_i |=> audio_output_select_reg_o == $past(out_sel_i))
        else $error("selection write lost");
    sel_keep_a: assert property (
        edge_q != 2'h0 && !out_sel_wr_i |=> $stable(audio_output_select_reg_o))
        else $error("selection changed without a write");
endmodule

// ==== sim/mas_speaker_model.sv ====
//
// Purpose: Far-side load: speaker across both pins or amplifier on pin a
// Assumes: Strap pin either tied high or left floating
// Notes:   A floating strap pin reads low through the pad pull-down
//
`timescale 1ns/1ps
module mas_speaker_model (
    // Strap and pins from the block
    input  wire logic       strap_high_i,
    input  wire logic       pin_a_oe_i,
    input  wire logic       pin_b_i,
    input  wire logic       pin_b_oe_i,
    // Sensed pin b level and load state
    output logic            pin_b_level_o,
    output logic [1:0]      load_mode_o
);
    // ****************************************
    // Wire level and load detection
    // ****************************************
    assign pin_b_level_o = strap_high_i ? 1'h1 : (pin_b_oe_i ? pin_b_i : 1'h0);
    // 1: speaker on both pins, 2: amplifier on pin a only
    assign load_mode_o = (pin_a_oe_i && pin_b_oe_i) ? 2'h1 : (pin_a_oe_i ? 2'h2 : 2'h0);
endmodule

// ==== sim/mas_synth_tb_top.sv ====
//
// Purpose: Self-checking bench of the synthesizer output block
// Assumes: 10 MHz clock, inputs driven on the falling edge
// Notes:   Fetch gaps and pointer steps are matched against queued notes
//
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin failures++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module mas_synth_tb_top;
    localparam int unsigned NC = mas_pkg::NUM_CH;
    logic            core_clk_i, reset_n_i, out_sel_wr, out_sel, strap_high;
    logic            sel, pa, pa_oe, pb, pb_oe, pb_level;
    logic [1:0]      mixer_mode, spk_mode;
    logic [3:0]      volume;
    logic [NC-1:0]   ch_start, ch_stop, ch_is_midi, ch_adpcm, ch_end, fetch, flag, quick_io_code, seen;
    logic [NC*8-1:0] ch_period, envelope, ch_data, pointer;
    logic [NC*2-1:0] ch_wave;
    logic [NC*3-1:0] ch_skip;
    logic [9:0]      dac;
    logic [3:0]      exp_fl [4] = '{4'h1, 4'h3, 4'hF, 4'hF};
    longint          last_t [NC];
    logic [7:0]      last_p [NC];
    int              failures, check_count, cycles, n, hi, lo;
    int              exp_q [NC][$];
    // ****************************************
    // Design and far side
    // ****************************************
    mas_synth u_mas_synth (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .mixer_mode_i(mixer_mode), .ch_start_i(ch_start), .ch_stop_i(ch_stop),
        .ch_is_midi_i(ch_is_midi), .ch_adpcm_i(ch_adpcm), .ch_period_i(ch_period),
        .envelope_value_i(envelope), .ch_wave_i(ch_wave), .ch_skip_i(ch_skip),
        .volume_i(volume), .out_sel_wr_i(out_sel_wr), .out_sel_i(out_sel), .ch_data_i(ch_data),
        .ch_data_end_i(ch_end), .channel_data_pointer_o(pointer), .ch_fetch_o(fetch),
        .channel_flag_reg_o(flag), .quick_io_code_o(quick_io_code), .audio_output_select_reg_o(sel),
        .audio_out_pin_b_i(pb_level), .audio_out_pin_a_o(pa), .audio_out_pin_a_oe_o(pa_oe),
        .audio_out_pin_b_o(pb), .audio_out_pin_b_oe_o(pb_oe), .dac_code_o(dac));
    mas_speaker_model u_mas_speaker_model (.strap_high_i(strap_high), .pin_a_oe_i(pa_oe),
        .pin_b_i(pb), .pin_b_oe_i(pb_oe), .pin_b_level_o(pb_level), .load_mode_o(spk_mode));
    initial begin
        core_clk_i = 1'h0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    // Each fetch after the first takes the oldest note of its channel
    always @(negedge core_clk_i) begin
        int note;
        for (int k = 0; k < NC; k++) begin
            if (fetch[k] === 1'h1) begin
                if (seen[k] && exp_q[k].size() > 0) begin
                    note = exp_q[k].pop_front();
                    `CHK("fetch gap", note / 16, int'(($time - last_t[k]) / 100))
                    `CHK("step", 8'(note % 16), 8'(pointer[k*8 +: 8] - last_p[k]))
                end
                seen[k] = 1'h1;
                last_t[k] = $time;
                last_p[k] = pointer[k*8 +: 8];
            end
        end
    end
    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic int pending();
        int s = 0;
        for (int k = 0; k < NC; k++) s += exp_q[k].size();
        return s;
    endfunction
    task automatic do_reset(input logic hi);
        @(negedge core_clk_i);
        reset_n_i = 1'h0;
        strap_high = hi;
        repeat (4) @(negedge core_clk_i);
        `CHK("oe in reset", 2'h0, {pa_oe, pb_oe})
        reset_n_i = 1'h1;
        @(negedge core_clk_i);
        `CHK("strap select", hi, sel)
        repeat (2) @(negedge core_clk_i);
        `CHK("load", hi ? 2'h2 : 2'h1, spk_mode)
    endtask
    task automatic write_sel(input logic v);
        out_sel = v;
        out_sel_wr = 1'h1;
        @(negedge core_clk_i);
        out_sel_wr = 1'h0;
        `CHK("select", v, sel)
        repeat (2) @(negedge core_clk_i);
        `CHK("load", v ? 2'h2 : 2'h1, spk_mode)
    endtask
    initial begin
        void'($urandom(21647));
        {reset_n_i, out_sel_wr, out_sel, strap_high, mixer_mode, ch_start, ch_stop} = '0;
        {ch_is_midi, ch_adpcm, ch_end, ch_period, envelope, ch_wave, ch_skip, volume} = '0;
        {ch_data, seen} = '0;
        do_reset(1'h1);
        // Strap low here, then the selection is written to DAC and back to PWM
        do_reset(1'h0);
        write_sel(1'h1);
        write_sel(1'h0);
        mixer_mode = mas_pkg::MIX_FOUR;
        volume = 4'($urandom);
        ch_data = $urandom;
        ch_adpcm = 4'($urandom);
        ch_is_midi = 4'($urandom);
        envelope = $urandom;
        for (int k = 0; k < NC; k++) begin
            ch_period[k*8 +: 8] = 8'hE9 + 8'($urandom_range(22));
            ch_skip[k*3 +: 3] = 3'($urandom);
            ch_wave[k*2 +: 2] = 2'(k % 3);
            repeat (3) exp_q[k].push_back((256 - ch_period[k*8 +: 8]) * 160
                + (ch_is_midi[k] ? ch_skip[k*3 +: 3] + 1 : 1));
        end
        ch_start = 4'hF;
        @(negedge core_clk_i);
        ch_start = 4'h0;
        `CHK("flags", 4'hF, flag)
        for (int i = 0; i < 5000 && pending() > 0; i++) @(negedge core_clk_i);
        `CHK("notes left", 0, pending())
        for (int m = 0; m < 4; m++) begin
            mixer_mode = 2'(m);
            ch_stop = 4'hF;
            @(negedge core_clk_i);
            ch_stop = 4'h0;
            ch_start = 4'hF;
            @(negedge core_clk_i);
            ch_start = 4'h0;
            `CHK("mode flags", exp_fl[m], flag)
        end
        mixer_mode = mas_pkg::MIX_ONE;
        @(negedge core_clk_i);
        `CHK("one flags", 4'h1, flag)
        ch_start = 4'h3;
        ch_stop = 4'h1;
        @(negedge core_clk_i);
        ch_start = 4'h0;
        `CHK("start wins", 4'h1, flag)
        @(negedge core_clk_i);
        ch_stop = 4'h0;
        `CHK("stopped", 4'h0, flag)
        ch_period[7:0] = 8'hFE;
        ch_start = 4'h1;
        @(negedge core_clk_i);
        ch_start = 4'h0;
        ch_end = 4'h1;
        for (int i = 0; i < 200 && flag[0] !== 1'h0; i++) @(negedge core_clk_i);
        `CHK("end stops", 1'h0, flag[0])
        ch_end = 4'h0;
        // Drain the sample FIFO in DAC mode, then play constant PCM bytes
        write_sel(1'h1);
        repeat (250) @(negedge core_clk_i);
        {ch_is_midi, ch_adpcm} = '0;
        ch_period = '1;
        ch_data = $urandom;
        mixer_mode = mas_pkg::MIX_FOUR;
        ch_start = 4'hF;
        @(negedge core_clk_i);
        ch_start = 4'h0;
        repeat (300) @(negedge core_clk_i);
        n = 0;
        for (int k = 0; k < NC; k++) n += ch_data[k*8 +: 8];
        n = (n * (volume + 1)) / 16;
        `CHK("dac code", 10'(n), dac)
        write_sel(1'h0);
        repeat (600) @(negedge core_clk_i);
        hi = 0;
        lo = 0;
        repeat (512) begin
            @(negedge core_clk_i);
            hi += (pa === 1'h1);
            lo += (pb === 1'h1);
        end
        `CHK("pwm high", n / 2, hi)
        `CHK("pwm low", 512 - n / 2, lo)
        stop_test();
    end
endmodule
bind mas_synth mas_synth_assertions #(.NUM_CH(NUM_CH)) u_mas_synth_assertions (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .mixer_mode_i(mixer_mode_i),
    .ch_start_i(ch_start_i), .ch_stop_i(ch_stop_i), .out_sel_wr_i(out_sel_wr_i),
    .out_sel_i(out_sel_i), .audio_out_pin_b_i(audio_out_pin_b_i), .ch_fetch_o(ch_fetch_o),
    .channel_flag_reg_o(channel_flag_reg_o), .quick_io_code_o(quick_io_code_o),
    .audio_output_select_reg_o(audio_output_select_reg_o),
    .audio_out_pin_a_oe_o(audio_out_pin_a_oe_o), .audio_out_pin_b_oe_o(audio_out_pin_b_oe_o));
